// *** crs_chirp_ramp_sequencer.sv ***
`timescale 1ns/1ps
// Function
// - Accumulator never drops below the 33-bit signed lower bound, reset zero.
// - Accumulator never exceeds the 33-bit signed upper bound, reset 0x0_FFFF_FFFF.
// - Clamping happens before the deviation offset is added.
// - Bound sign bits live in bits 3 and 4 of the shared high-bit register.
// - 13-bit ramp count stops the sweep; zero disables the counter.
// - Ramp counter clears when sweep enable rises.
// - Auto-stop bit clears sweep enable at terminal count.
// - Count source: segment transitions, or trigger A, B or C.
// - Eight independent segment descriptors, index 0 to 7.
// - Active segment adds its signed 30-bit step each tick until length expires.
// - Segment fastlock bit drives fastlock output during the segment.
// - Segment slowdown bit makes each tick last two clocks.
// - Segment duration in ticks, 1 means one, 0 means 65536.
// - Advance condition: length expiry, or trigger A, B or C.
// - Successor field picks the next segment.
// - Accumulator-clear bit loads zero, clamped to the bounds, into the accumulator on segment entry.
// - Two-bit code drives the two output flags.
module crs_chirp_ramp_sequencer #(
  parameter int NSEG = 8,
  parameter int CNT_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Trigger events, one-cycle pulses
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic trig_c,
  // Ramp outputs
  output crs_pkg::crs_out_t ramp_out
);
  import crs_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Segment slot: {hit, index, word offset}
  function automatic logic [15:0] seg_dec(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - CRS_SEG_BASE;
    seg_dec = '0;
    if (a >= CRS_SEG_BASE && rel < 12'(NSEG * 16) && rel[3:0] <= CRS_SEG_CTL_OFS[3:0]) begin
      seg_dec = {1'b1, rel[6:4], rel[3:0], 8'h00};
    end
  endfunction : seg_dec

  function automatic logic trig_pick(input logic [1:0] sel, input logic a, input logic b, input logic c);
    unique case (sel)
      2'd1: trig_pick = a;
      2'd2: trig_pick = b;
      2'd3: trig_pick = c;
      default: trig_pick = 1'b0;
    endcase
  endfunction : trig_pick

  // ==========================================
  // Bus channel state
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic awready_reg, wready_reg, arready_reg;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_wr, wr_hit;
  logic [32:0] rd_word;

  // ==========================================
  // Register state
  logic sweep_en_reg, sweep_en_next;
  logic [31:0] lim_lo_reg, lim_lo_next, lim_hi_reg, lim_hi_next, dev_reg, dev_next;
  logic [7:0] msb_reg, msb_next, cnt_low_reg, cnt_low_next, cnt_ctrl_reg, cnt_ctrl_next;
  logic [29:0] step_reg [NSEG], step_next [NSEG];
  logic [15:0] dur_reg [NSEG], dur_next [NSEG];
  crs_segctl_t sctl_reg [NSEG], sctl_next [NSEG];

  // ==========================================
  // Sequencer state
  crs_state_t state_reg, state_next;
  logic sweep_q_reg;
  logic [2:0] seg_reg, seg_next;
  logic [16:0] len_reg, len_next;
  logic phase_reg, phase_next;
  logic [32:0] acc_reg, acc_next;
  crs_out_t out_reg, out_next;
  logic [32:0] lower, upper, dev33, cand_seg;
  logic [33:0] cand;
  logic [32:0] clamped;
  logic start, seg_pulse, cnt_inc, terminal, auto_stop;
  logic [CNT_W-1:0] ramp_count;
  logic [2:0] nseg;
  crs_segctl_t cur;

  assign lower = {msb_reg[CRS_MSB_LO_BIT], lim_lo_reg};
  assign upper = {msb_reg[CRS_MSB_HI_BIT], lim_hi_reg};
  assign dev33 = {msb_reg[CRS_MSB_DEV_BIT], dev_reg};
  assign cur = sctl_reg[seg_reg];

  // ==========================================
  // Write channels
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
    if (awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = awaddr;
    end
    if (wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = wdata;
      w_strb_next = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? CRS_RESP_OKAY : CRS_RESP_SLVERR;
    end
  end

  // ==========================================
  // Read channel
  always_comb begin
    logic [15:0] sd;
    logic [2:0] si;
    sd = seg_dec(araddr);
    si = sd[14:12];
    rd_word = {1'b1, 32'h0000_0000};
    unique case (araddr)
      CRS_CTRL_OFS: rd_word[0] = sweep_en_reg;
      CRS_STATUS_OFS: rd_word[31:0] = {3'b000, ramp_count, 9'h000, out_reg.flags, out_reg.fastlock,
        out_reg.segment, out_reg.active};
      CRS_LIM_LO_OFS: rd_word[31:0] = lim_lo_reg;
      CRS_LIM_HI_OFS: rd_word[31:0] = lim_hi_reg;
      CRS_DEV_OFS: rd_word[31:0] = dev_reg;
      CRS_ACC_LO_OFS: rd_word[31:0] = acc_reg[31:0];
      CRS_ACC_HI_OFS: rd_word[0] = acc_reg[32];
      CRS_MSB_OFS: rd_word[7:0] = msb_reg;
      CRS_CNT_LOW_OFS: rd_word[7:0] = cnt_low_reg;
      CRS_CNT_CTRL_OFS: rd_word[7:0] = cnt_ctrl_reg;
      default: begin
        rd_word[32] = sd[15];
        if (sd[11:8] == CRS_SEG_STEP_OFS[3:0]) begin
          rd_word[31:0] = {{2{step_reg[si][29]}}, step_reg[si]};
        end else if (sd[11:8] == CRS_SEG_DUR_OFS[3:0]) begin
          rd_word[15:0] = dur_reg[si];
        end else begin
          rd_word[9:0] = sctl_reg[si];
        end
      end
    endcase
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word[32] ? rd_word[31:0] : 32'h0000_0000;
      rresp_next = rd_word[32] ? CRS_RESP_OKAY : CRS_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CRS_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= CRS_RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else begin
      aw_full_reg <= aw_full_next;
      awready_reg <= !aw_full_next;
      wready_reg <= !w_full_next;
      arready_reg <= !rvalid_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // ==========================================
  // Register file
  always_comb begin
    logic [15:0] sd;
    logic [2:0] si;
    logic [31:0] m;
    m = 32'h0000_0000;
    sd = seg_dec(aw_addr_reg);
    si = sd[14:12];
    sweep_en_next = sweep_en_reg;
    lim_lo_next = lim_lo_reg;
    lim_hi_next = lim_hi_reg;
    dev_next = dev_reg;
    msb_next = msb_reg;
    cnt_low_next = cnt_low_reg;
    cnt_ctrl_next = cnt_ctrl_reg;
    step_next = step_reg;
    dur_next = dur_reg;
    sctl_next = sctl_reg;
    wr_hit = 1'b1;
    if (auto_stop) begin
      sweep_en_next = 1'b0;
    end
    unique case (aw_addr_reg)
      CRS_CTRL_OFS: m = merge({31'h0000_0000, sweep_en_reg}, w_data_reg, w_strb_reg);
      CRS_LIM_LO_OFS: m = merge(lim_lo_reg, w_data_reg, w_strb_reg);
      CRS_LIM_HI_OFS: m = merge(lim_hi_reg, w_data_reg, w_strb_reg);
      CRS_DEV_OFS: m = merge(dev_reg, w_data_reg, w_strb_reg);
      CRS_MSB_OFS: m = merge({24'h00_0000, msb_reg}, w_data_reg, w_strb_reg);
      CRS_CNT_LOW_OFS: m = merge({24'h00_0000, cnt_low_reg}, w_data_reg, w_strb_reg);
      CRS_CNT_CTRL_OFS: m = merge({24'h00_0000, cnt_ctrl_reg}, w_data_reg, w_strb_reg);
      default: begin
        if (sd[11:8] == CRS_SEG_STEP_OFS[3:0]) begin
          m = merge({2'b00, step_reg[si]}, w_data_reg, w_strb_reg);
        end else if (sd[11:8] == CRS_SEG_DUR_OFS[3:0]) begin
          m = merge({16'h0000, dur_reg[si]}, w_data_reg, w_strb_reg);
        end else begin
          m = merge({22'h00_0000, sctl_reg[si]}, w_data_reg, w_strb_reg);
        end
      end
    endcase
    unique case (aw_addr_reg)
      CRS_CTRL_OFS: if (do_wr) sweep_en_next = m[0];
      CRS_LIM_LO_OFS: if (do_wr) lim_lo_next = m;
      CRS_LIM_HI_OFS: if (do_wr) lim_hi_next = m;
      CRS_DEV_OFS: if (do_wr) dev_next = m;
      CRS_MSB_OFS: if (do_wr) msb_next = m[7:0];
      CRS_CNT_LOW_OFS: if (do_wr) cnt_low_next = m[7:0];
      CRS_CNT_CTRL_OFS: if (do_wr) cnt_ctrl_next = m[7:0];
      CRS_STATUS_OFS, CRS_ACC_LO_OFS, CRS_ACC_HI_OFS: wr_hit = 1'b1;
      default: begin
        wr_hit = sd[15];
        if (do_wr && sd[15]) begin
          if (sd[11:8] == CRS_SEG_STEP_OFS[3:0]) begin
            step_next[si] = m[29:0];
          end else if (sd[11:8] == CRS_SEG_DUR_OFS[3:0]) begin
            dur_next[si] = m[15:0];
          end else begin
            sctl_next[si] = m[9:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sweep_en_reg <= 1'b0;
      lim_lo_reg <= CRS_LIM_LO_RST[31:0];
      lim_hi_reg <= CRS_LIM_HI_RST[31:0];
      dev_reg <= 32'h0000_0000;
      msb_reg <= {3'b000, CRS_LIM_HI_RST[32], CRS_LIM_LO_RST[32], 3'b000};
      cnt_low_reg <= CRS_BYTE_RST;
      cnt_ctrl_reg <= CRS_BYTE_RST;
      for (int i = 0; i < NSEG; i++) begin
        step_reg[i] <= 30'h0000_0000;
        dur_reg[i] <= 16'h0000;
        sctl_reg[i] <= '0;
      end
    end else begin
      sweep_en_reg <= sweep_en_next;
      lim_lo_reg <= lim_lo_next;
      lim_hi_reg <= lim_hi_next;
      dev_reg <= dev_next;
      msb_reg <= msb_next;
      cnt_low_reg <= cnt_low_next;
      cnt_ctrl_reg <= cnt_ctrl_next;
      step_reg <= step_next;
      dur_reg <= dur_next;
      sctl_reg <= sctl_next;
    end
  end

  // ==========================================
  // Ramp counter
  assign start = sweep_en_reg && !sweep_q_reg;
  assign cnt_inc = (cnt_ctrl_reg[CRS_SRC_LSB +: 2] == 2'd0) ? seg_pulse
    : trig_pick(cnt_ctrl_reg[CRS_SRC_LSB +: 2], trig_a, trig_b, trig_c);
  assign auto_stop = cnt_ctrl_reg[CRS_AUTO_BIT] && terminal && sweep_q_reg;

  crs_ramp_counter #(
    .W(CNT_W)
  ) u_count (
    .clk(clk),
    .resetn(resetn),
    .clear(start),
    .inc(cnt_inc && sweep_en_reg),
    .limit({cnt_ctrl_reg[CRS_CNT_HI_W-1:0], cnt_low_reg}),
    .count(ramp_count),
    .terminal(terminal)
  );

  // ==========================================
  // Segment sequencer
  crs_clamp #(
    .W(33)
  ) u_clamp (
    .cand(cand),
    .lower(lower),
    .upper(upper),
    .result(clamped)
  );

  always_comb begin
    logic tick, expire;
    state_next = state_reg;
    seg_next = seg_reg;
    len_next = len_reg;
    phase_next = phase_reg;
    seg_pulse = 1'b0;
    nseg = seg_reg;
    cand_seg = acc_reg;
    tick = !cur.slowdown || phase_reg;
    expire = 1'b0;
    unique case (state_reg)
      CRS_IDLE: begin
        if (start) begin
          state_next = CRS_RUN;
          nseg = 3'd0;
        end
      end
      CRS_RUN: begin
        if (!sweep_en_reg) begin
          state_next = CRS_IDLE;
        end else begin
          phase_next = cur.slowdown ? !phase_reg : 1'b0;
          if (tick && len_reg != 17'd0) begin
            cand_seg = acc_reg + {{3{step_reg[seg_reg][29]}}, step_reg[seg_reg]};
            len_next = len_reg - 17'd1;
            expire = (len_reg == 17'd1);
          end
          if (cur.advance_cond == 2'd0 ? expire
              : trig_pick(cur.advance_cond, trig_a, trig_b, trig_c)) begin
            nseg = cur.successor;
            seg_pulse = 1'b1;
          end
        end
      end
    endcase
    if (start || seg_pulse) begin
      seg_next = nseg;
      len_next = {dur_reg[nseg] == 16'h0000, dur_reg[nseg]};
      phase_next = 1'b0;
      if (sctl_reg[nseg].accum_clear) begin
        cand_seg = 33'h0_0000_0000;
      end
    end
    cand = {cand_seg[32], cand_seg};
    acc_next = (state_reg == CRS_RUN || start) ? clamped : acc_reg;
    out_next.value = acc_next + dev33;
    out_next.segment = seg_next;
    out_next.fastlock = (state_next == CRS_RUN) && sctl_reg[seg_next].fastlock;
    out_next.flags = (state_next == CRS_RUN) ? sctl_reg[seg_next].flags : 2'b00;
    out_next.active = (state_next == CRS_RUN);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= CRS_IDLE;
      sweep_q_reg <= 1'b0;
      seg_reg <= 3'd0;
      len_reg <= 17'd0;
      phase_reg <= 1'b0;
      acc_reg <= 33'h0_0000_0000;
      out_reg <= '0;
    end else begin
      state_reg <= state_next;
      sweep_q_reg <= sweep_en_reg;
      seg_reg <= seg_next;
      len_reg <= len_next;
      phase_reg <= phase_next;
      acc_reg <= acc_next;
      out_reg <= out_next;
    end
  end

  assign ramp_out = out_reg;
endmodule : crs_chirp_ramp_sequencer

// *** crs_pkg.sv ***
package crs_pkg;
  // ==========================================
  // Register word offsets (byte addresses)
  localparam logic [11:0] CRS_CTRL_OFS = 12'h000;
  localparam logic [11:0] CRS_STATUS_OFS = 12'h004;
  localparam logic [11:0] CRS_LIM_LO_OFS = 12'h008;
  localparam logic [11:0] CRS_LIM_HI_OFS = 12'h00C;
  localparam logic [11:0] CRS_DEV_OFS = 12'h010;
  localparam logic [11:0] CRS_ACC_LO_OFS = 12'h014;
  localparam logic [11:0] CRS_ACC_HI_OFS = 12'h018;
  localparam logic [9:0] CRS_MSB_IDX = 10'h046;
  localparam logic [9:0] CRS_CNT_LOW_IDX = 10'h053;
  localparam logic [9:0] CRS_CNT_CTRL_IDX = 10'h054;
  localparam logic [11:0] CRS_MSB_OFS = {CRS_MSB_IDX, 2'b00};
  localparam logic [11:0] CRS_CNT_LOW_OFS = {CRS_CNT_LOW_IDX, 2'b00};
  localparam logic [11:0] CRS_CNT_CTRL_OFS = {CRS_CNT_CTRL_IDX, 2'b00};
  localparam logic [11:0] CRS_SEG_BASE = 12'h200;
  localparam logic [11:0] CRS_SEG_STEP_OFS = 12'h000;
  localparam logic [11:0] CRS_SEG_DUR_OFS = 12'h004;
  localparam logic [11:0] CRS_SEG_CTL_OFS = 12'h008;
  // ==========================================
  // Field positions
  localparam int CRS_MSB_DEV_BIT = 2;
  localparam int CRS_MSB_LO_BIT = 3;
  localparam int CRS_MSB_HI_BIT = 4;
  localparam int CRS_AUTO_BIT = 5;
  localparam int CRS_SRC_LSB = 6;
  localparam int CRS_CNT_HI_W = 5;
  // ==========================================
  // Reset values
  localparam logic [32:0] CRS_LIM_LO_RST = 33'h0_0000_0000;
  localparam logic [32:0] CRS_LIM_HI_RST = 33'h0_FFFF_FFFF;
  localparam logic [7:0] CRS_BYTE_RST = 8'h00;
  // ==========================================
  // AXI responses
  localparam logic [1:0] CRS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CRS_RESP_SLVERR = 2'b10;
  // ==========================================
  // Types
  typedef enum logic [1:0] {
    CRS_IDLE = 2'b01,
    CRS_RUN = 2'b10
  } crs_state_t;

  typedef struct packed {
    logic [1:0] flags;
    logic accum_clear;
    logic [2:0] successor;
    logic [1:0] advance_cond;
    logic slowdown;
    logic fastlock;
  } crs_segctl_t;

  typedef struct packed {
    logic [32:0] value;
    logic [2:0] segment;
    logic fastlock;
    logic [1:0] flags;
    logic active;
  } crs_out_t;
endpackage : crs_pkg

// *** crs_clamp.sv ***
`timescale 1ns/1ps
module crs_clamp #(
  parameter int W = 33
) (
  // Candidate, one bit wider than result
  input wire logic [W:0] cand,
  // Bounds, two's complement
  input wire logic [W-1:0] lower,
  input wire logic [W-1:0] upper,
  // Clamped value
  output logic [W-1:0] result
);
  logic signed [W:0] c_s;
  logic signed [W:0] lo_s;
  logic signed [W:0] hi_s;

  always_comb begin
    c_s = $signed(cand);
    lo_s = $signed({lower[W-1], lower});
    hi_s = $signed({upper[W-1], upper});
    if (c_s < lo_s) begin
      result = lower;
    end else if (c_s > hi_s) begin
      result = upper;
    end else begin
      result = cand[W-1:0];
    end
  end
endmodule : crs_clamp

// *** crs_ramp_counter.sv ***
`timescale 1ns/1ps
module crs_ramp_counter #(
  parameter int W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic inc,
  input wire logic [W-1:0] limit,
  // State
  output logic [W-1:0] count,
  output logic terminal
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (inc && (limit != '0) && (count_reg != limit)) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign terminal = (limit != '0) && (count_reg == limit);
endmodule : crs_ramp_counter

// *** crs_chirp_ramp_sequencer_chk.sv ***
`timescale 1ns/1ps
module crs_chirp_ramp_sequencer_chk #(
  parameter int NSEG = 8,
  parameter int CNT_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Triggers and ramp
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic trig_c,
  input wire crs_pkg::crs_out_t ramp_out
);
  import crs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Bus handshakes
  AST_AR_READY: assert property (arready == !rvalid) else $error("arready not inverse of rvalid");
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid) else $error("read data late");
  AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("rd drop");
  AST_RD_END: assert property (rvalid && rready |=> !rvalid) else $error("rvalid stuck");
  AST_AW_SLOT: assert property (awvalid && awready |=> !awready) else $error("aw slot not held");
  AST_WR_LAT: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write resp late");
  AST_WR_BUSY: assert property ($rose(bvalid) |-> awready && wready) else $error("slots not freed by write");
  AST_WR_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write resp dropped");
  // ==========================================
  // Ramp outputs
  AST_IDLE_OUT: assert property (!ramp_out.active |-> ramp_out.flags == 2'b00 && !ramp_out.fastlock) else $error("idle out");
  AST_IDLE_SEG: assert property (!ramp_out.active && !$past(ramp_out.active) |-> $stable(ramp_out.segment)) else $error("seg moved");
  AST_START_SEG: assert property ($rose(ramp_out.active) |-> ramp_out.segment == 3'd0) else $error("start seg");
  cover property (bvalid && bready && bresp == CRS_RESP_SLVERR);
  cover property ($rose(ramp_out.active));
  cover property ($fell(ramp_out.active));
  cover property (ramp_out.segment == 3'd2 && ramp_out.flags == 2'd3);
endmodule : crs_chirp_ramp_sequencer_chk

bind crs_chirp_ramp_sequencer crs_chirp_ramp_sequencer_chk #(.NSEG(NSEG), .CNT_W(CNT_W)) i_crs_chirp_ramp_sequencer_chk (
  .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .trig_a(trig_a), .trig_b(trig_b), .trig_c(trig_c), .ramp_out(ramp_out));

// *** test_chirp_ramp_sequencer.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_chirp_ramp_sequencer;
  import crs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic trig_a = 1'b0, trig_b = 1'b0, trig_c = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  crs_out_t ramp_out;
  int miscompares = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  crs_chirp_ramp_sequencer i_crs_chirp_ramp_sequencer (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .trig_a(trig_a), .trig_b(trig_b), .trig_c(trig_c), .ramp_out(ramp_out));

  // ==========================================
  // Shared tasks
  task test_done;
    $display("Mismatches %0d of %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task tmo;
    miscompares++;
    $display("Error at %0t: wait ran out", $time);
    test_done();
  endtask : tmo

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) tmo();
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  task rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) tmo();
    rready <= 1'b0;
    `CHK(rdata & m, e)
    `CHK(rresp, er)
  endtask : rd_chk

  task seg_cfg(input logic [2:0] s, input logic [29:0] st, input logic [15:0] d, input crs_segctl_t c);
    logic [11:0] b;
    b = CRS_SEG_BASE + {5'h00, s, 4'h0};
    wr(b + CRS_SEG_STEP_OFS, {2'b00, st}, CRS_RESP_OKAY);
    wr(b + CRS_SEG_DUR_OFS, {16'h0000, d}, CRS_RESP_OKAY);
    wr(b + CRS_SEG_CTL_OFS, {22'h00_0000, c}, CRS_RESP_OKAY);
  endtask : seg_cfg

  task wait_out(input logic [2:0] s, input logic act);
    int n;
    for (n = 0; n < 100 && (ramp_out.segment !== s || ramp_out.active !== act); n++) @(negedge clk);
    if (n == 100) tmo();
  endtask : wait_out

  task pulse(input logic [1:0] k);
    @(posedge clk);
    trig_a <= (k == 2'd1);
    trig_b <= (k == 2'd2);
    trig_c <= (k == 2'd3);
    @(posedge clk);
    trig_a <= 1'b0;
    trig_b <= 1'b0;
    trig_c <= 1'b0;
  endtask : pulse

  task restart;
    wr(CRS_CTRL_OFS, 32'h0000_0000, CRS_RESP_OKAY);
    wr(CRS_CTRL_OFS, 32'h0000_0001, CRS_RESP_OKAY);
    wait_out(3'd0, 1'b1);
  endtask : restart

  // ==========================================
  // Scenarios
  task reset_vals;
    rd_chk(CRS_LIM_LO_OFS, 32'hFFFF_FFFF, 32'h0000_0000, CRS_RESP_OKAY);
    rd_chk(CRS_LIM_HI_OFS, 32'hFFFF_FFFF, 32'hFFFF_FFFF, CRS_RESP_OKAY);
    rd_chk(CRS_MSB_OFS, 32'h0000_0018, 32'h0000_0000, CRS_RESP_OKAY);
    rd_chk(CRS_CNT_LOW_OFS, 32'h0000_00FF, 32'h0000_0000, CRS_RESP_OKAY);
    rd_chk(CRS_CNT_CTRL_OFS, 32'h0000_00FF, 32'h0000_0000, CRS_RESP_OKAY);
    wr(12'h0FC, 32'h1234_5678, CRS_RESP_SLVERR);
    rd_chk(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000, CRS_RESP_SLVERR);
  endtask : reset_vals

  task ramp_run;
    wr(CRS_LIM_LO_OFS, 32'hFFFF_FFF8, CRS_RESP_OKAY);
    wr(CRS_MSB_OFS, 32'h0000_0008, CRS_RESP_OKAY);
    wr(CRS_LIM_HI_OFS, 32'h0000_0050, CRS_RESP_OKAY);
    wr(CRS_DEV_OFS, 32'h0000_0100, CRS_RESP_OKAY);
    seg_cfg(3'd0, 30'h0000_0005, 16'h0003, '{2'd1, 1'b1, 3'd1, 2'd1, 1'b0, 1'b1});
    seg_cfg(3'd1, 30'h3FFF_FFEC, 16'h0002, '{2'd2, 1'b0, 3'd2, 2'd2, 1'b1, 1'b0});
    seg_cfg(3'd2, 30'h0000_1000, 16'h0000, '{2'd3, 1'b1, 3'd2, 2'd0, 1'b0, 1'b0});
    wr(CRS_CTRL_OFS, 32'h0000_0001, CRS_RESP_OKAY);
    wait_out(3'd0, 1'b1);
    repeat (10) @(negedge clk);
    `CHK(ramp_out.value, 33'h0_0000_010F)
    `CHK(ramp_out.fastlock, 1'b1)
    `CHK(ramp_out.flags, 2'd1)
    pulse(2'd1);
    wait_out(3'd1, 1'b1);
    `CHK(ramp_out.value, 33'h0_0000_010F)
    @(negedge clk);
    `CHK(ramp_out.value, 33'h0_0000_010F)
    repeat (10) @(negedge clk);
    `CHK(ramp_out.value, 33'h0_0000_00F8)
    `CHK(ramp_out.flags, 2'd2)
    `CHK(ramp_out.fastlock, 1'b0)
    pulse(2'd2);
    wait_out(3'd2, 1'b1);
    `CHK(ramp_out.value, 33'h0_0000_0100)
    repeat (5) @(negedge clk);
    `CHK(ramp_out.value, 33'h0_0000_0150)
    `CHK(ramp_out.flags, 2'd3)
    `CHK(ramp_out.segment, 3'd2)
    rd_chk(CRS_ACC_LO_OFS, 32'hFFFF_FFFF, 32'h0000_0050, CRS_RESP_OKAY);
  endtask : ramp_run

  task count_src;
    int k;
    wr(CRS_CNT_LOW_OFS, 32'h0000_0005, CRS_RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      wr(CRS_CNT_CTRL_OFS, {24'h00_0000, k[1:0], 6'h00}, CRS_RESP_OKAY);
      restart();
      pulse(k == 0 ? 2'd1 : k[1:0]);
      rd_chk(CRS_STATUS_OFS, 32'h1FFF_0000, 32'h0001_0000, CRS_RESP_OKAY);
    end
  endtask : count_src

  task auto_stop;
    wr(CRS_CNT_LOW_OFS, 32'h0000_0000, CRS_RESP_OKAY);
    wr(CRS_CNT_CTRL_OFS, 32'h0000_00E0, CRS_RESP_OKAY);
    restart();
    pulse(2'd3);
    repeat (3) @(negedge clk);
    `CHK(ramp_out.active, 1'b1)
    wr(CRS_CNT_LOW_OFS, 32'h0000_0002, CRS_RESP_OKAY);
    restart();
    pulse(2'd3);
    @(negedge clk);
    `CHK(ramp_out.active, 1'b1)
    pulse(2'd3);
    wait_out(3'd0, 1'b0);
    repeat (5) @(negedge clk);
    `CHK(ramp_out.value, 33'h0_0000_010F)
    rd_chk(CRS_CTRL_OFS, 32'h0000_0001, 32'h0000_0000, CRS_RESP_OKAY);
    rd_chk(CRS_STATUS_OFS, 32'h1FFF_0000, 32'h0002_0000, CRS_RESP_OKAY);
  endtask : auto_stop

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    reset_vals();
    ramp_run();
    count_src();
    auto_stop();
    test_done();
  end
endmodule : test_chirp_ramp_sequencer
